// *** core/emi_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01 - four phases: setup, data setup, transfer, hold
// R02 - each phase half a processor clock
// R03 - setup phase starts on clock rising edge
// R04 - data setup stretched by whole wait periods
// R05 - internal access: word address, strobes idle, float
// R06 - DMA floats address, data, enable, strobes
// R07 - address valid from setup to hold end
// R08 - read data sampled in hold phase
// R09 - memory releases data by mid setup
// R10 - write data driven data setup to hold
// R11 - data floats except written byte lanes
// R12 - word both strobes, byte one strobe; code strobes both lanes in second cycle of a byte-mode high byte write
// R13 - strobes follow chip enable, high between
// R14 - strobes float in DMA, idle internally
// R15 - chip enable low on reads and writes
// R16 - latch byte-wide select in data setup
// R17 - byte mode: low byte, then address+1
// R18 - sample wait in data setup phase
// R19 - internal accesses ignore wait request
// R20 - float bus before granting DMA
// R21 - sample DMA request early in access
// R22 - idle: sample DMA request each rise
// R23 - reads fetch full word, select internally
// R24 - strobe edges timed from clock edges
// R25 - second byte cycle uses low lanes only; code puts data on low lane but enables both strobe lanes for word and high byte writes
// R26 - resample wait in wait second half
// R27 - request withdrawn: regrant bus, restart access
module emi_ctrl
    import emi_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic reqValid,
    input wire logic reqExt,
    input wire logic reqWrite,
    input wire logic reqByte,
    input wire logic [AW-1:0] reqAddr,
    input wire logic [DW-1:0] reqWdata,
    output logic reqReady,
    output logic [7:0] rdByte,
    output logic [DW-1:0] rdWord,
    output logic rdValid,
    output logic [AW-1:0] ext_addr_bus,
    output logic ext_addr_bus_oe,
    input wire logic [DW-1:0] ext_data_bus_in,
    output logic [DW-1:0] ext_data_bus_out,
    output logic [1:0] ext_data_bus_oe,
    output logic ext_chip_select_n,
    output logic ext_chip_select_n_oe,
    output logic [1:0] byte_write_strobes_n,
    output logic byte_write_strobes_n_oe,
    input wire logic byte_wide_select,
    input wire logic wait_request,
    input wire logic dma_request,
    output logic dma_grant,
    output logic processor_clock_output
);
    logic rstSync1_r, rstN_r;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rstSync1_r <= 1'b0;
            rstN_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstN_r <= rstSync1_r;
        end
    end

    logic phaseTick, procClkHigh;
    emi_clkgen u_clk (
        .sys_clk(sys_clk),
        .rstN(rstN_r),
        .phaseTick(phaseTick),
        .procClkHigh(procClkHigh)
    );
    // next phase begins on a rising edge when clock is currently low
    logic riseNext;
    assign riseNext = phaseTick && !procClkHigh; // R24

    // dma request is asynchronous: two-stage synchroniser
    logic dmaS1_r, dmaS2_r;
    always_ff @(posedge sys_clk or negedge rstN_r) begin
        if (!rstN_r) begin
            dmaS1_r <= 1'b0;
            dmaS2_r <= 1'b0;
        end else begin
            dmaS1_r <= dma_request;
            dmaS2_r <= dmaS1_r;
        end
    end

    emi_state_t state_r, state_nxt;
    logic write_r, byteOp_r, second_r, byteMode_r, hiByte_r, internal_r;
    logic [AW-1:0] addr_r;
    logic [DW-1:0] wdata_r, rword_r;
    logic grant_r, floatBus_r, dmaPend_r;

    // data setup always lands in a low phase, so the phase after it is the
    // first high phase with chip enable low; one look per cycle only
    logic firstHigh_r;
    always_ff @(posedge sys_clk or negedge rstN_r) begin
        if (!rstN_r) begin
            firstHigh_r <= 1'b0;
        end else begin
            firstHigh_r <= (state_r == EMI_DATA_SETUP) && phaseTick;
        end
    end

    logic inAccess;
    assign inAccess = (state_r != EMI_IDLE);
    // sample dma in first high phase after chip enable falls, else each rise
    logic dmaSample;
    assign dmaSample = inAccess ? firstHigh_r // R21
                                : riseNext; // R22
    logic accEnd;
    assign accEnd = (state_r == EMI_HOLD) && phaseTick;
    logic needSecond;
    assign needSecond = byteMode_r && !second_r && !internal_r; // R16 R17
    logic waitNow;
    assign waitNow = wait_request && !internal_r; // R19

    always_comb begin
        state_nxt = state_r;
        if (phaseTick) begin
            case (state_r)
                EMI_IDLE: state_nxt = EMI_IDLE;
                EMI_ADDR_SETUP: state_nxt = EMI_DATA_SETUP; // R01 R02
                EMI_DATA_SETUP: state_nxt = waitNow ? EMI_WAIT1 : EMI_XFER; // R18 R04
                EMI_WAIT1: state_nxt = EMI_WAIT2;
                EMI_WAIT2: state_nxt = waitNow ? EMI_WAIT1 : EMI_XFER; // R26
                EMI_XFER: state_nxt = EMI_HOLD;
                EMI_HOLD: state_nxt = needSecond ? EMI_ADDR_SETUP : EMI_IDLE;
                default: state_nxt = EMI_IDLE;
            endcase
        end
    end

    logic startAcc;
    // new access only on rising edge and while bus is ours
    assign startAcc = (state_r == EMI_IDLE) && riseNext && reqValid
                      && !grant_r && !dmaPend_r; // R03 R27

    always_ff @(posedge sys_clk or negedge rstN_r) begin
        if (!rstN_r) begin
            state_r <= EMI_IDLE;
            write_r <= 1'b0;
            byteOp_r <= 1'b0;
            hiByte_r <= 1'b0;
            second_r <= 1'b0;
            byteMode_r <= 1'b0;
            internal_r <= 1'b0;
            addr_r <= ADDR_RST;
            wdata_r <= DATA_RST;
            rword_r <= DATA_RST;
            rdValid <= 1'b0;
            reqReady <= 1'b0;
        end else begin
            rdValid <= 1'b0;
            reqReady <= 1'b0;
            if (startAcc) begin
                state_r <= EMI_ADDR_SETUP;
                write_r <= reqWrite;
                byteOp_r <= reqByte;
                hiByte_r <= reqAddr[0];
                internal_r <= !reqExt;
                addr_r <= {reqAddr[AW-1:1], 1'b0};
                wdata_r <= reqWdata;
                second_r <= 1'b0;
                byteMode_r <= 1'b0;
                reqReady <= 1'b1;
            end else begin
                state_r <= state_nxt;
            end
            if (state_r == EMI_DATA_SETUP && phaseTick && !second_r) begin
                byteMode_r <= byte_wide_select; // R16
            end
            if (state_r == EMI_XFER && phaseTick && !write_r) begin
                if (second_r) begin
                    rword_r[15:8] <= ext_data_bus_in[7:0]; // R08 R25
                end else if (byteMode_r) begin
                    rword_r[7:0] <= ext_data_bus_in[7:0];
                end else begin
                    rword_r <= internal_r ? DATA_RST : ext_data_bus_in;
                end
            end
            if (accEnd && needSecond) begin
                second_r <= 1'b1;
                addr_r[0] <= 1'b1; // R17
            end
            if (accEnd && !needSecond && !write_r) begin
                rdValid <= 1'b1;
            end
        end
    end

    // dma handshake: float first, grant one cycle later
    always_ff @(posedge sys_clk or negedge rstN_r) begin
        if (!rstN_r) begin
            dmaPend_r <= 1'b0;
            floatBus_r <= 1'b0;
            grant_r <= 1'b0;
        end else begin
            if (dmaSample) begin
                dmaPend_r <= dmaS2_r;
            end
            if (dmaPend_r && !inAccess) begin
                floatBus_r <= 1'b1; // R06 R20
            end
            grant_r <= floatBus_r && dmaPend_r; // R20
            if (!dmaS2_r && !inAccess) begin
                dmaPend_r <= 1'b0;
                grant_r <= 1'b0;
                floatBus_r <= grant_r; // R27
            end
        end
    end

    logic extCyc, ceOn, dataPh, wrLo, wrHi;
    assign extCyc = inAccess && !internal_r;
    assign ceOn = extCyc && (state_r != EMI_ADDR_SETUP)
                  && (state_r != EMI_HOLD); // R15 R13
    assign dataPh = extCyc && write_r && (state_r != EMI_ADDR_SETUP); // R10
    // byte lanes per cycle: second cycle gives both strobe lanes the same enable, data goes on the low lane only
    function automatic logic laneOn(input logic sec, input logic byteOp,
                                    input logic hiSel, input logic lane);
        logic on;
        if (sec) begin
            // upper byte of the word moves on the low lanes here
            on = !byteOp || hiSel;
        end else if (lane) begin
            on = !byteOp || hiSel;
        end else begin
            on = !byteOp || !hiSel;
        end
        return on;
    endfunction

    assign wrLo = laneOn(second_r, byteOp_r, hiByte_r, 1'b0); // R12
    assign wrHi = laneOn(second_r, byteOp_r, hiByte_r, 1'b1); // R12

    always_ff @(posedge sys_clk or negedge rstN_r) begin
        if (!rstN_r) begin
            ext_addr_bus <= ADDR_RST;
            ext_addr_bus_oe <= 1'b1;
            ext_data_bus_out <= DATA_RST;
            ext_data_bus_oe <= 2'b00;
            ext_chip_select_n <= 1'b1;
            ext_chip_select_n_oe <= 1'b1;
            byte_write_strobes_n <= 2'b11;
            byte_write_strobes_n_oe <= 1'b1;
        end else begin
            ext_addr_bus_oe <= !floatBus_r; // R06
            ext_chip_select_n_oe <= !floatBus_r;
            byte_write_strobes_n_oe <= !floatBus_r; // R14
            ext_addr_bus <= addr_r; // R07 R05
            ext_chip_select_n <= !ceOn; // R05
            byte_write_strobes_n <= (ceOn && write_r) ?
                                    {!wrHi, !wrLo} : 2'b11; // R13 R14
            ext_data_bus_out <= second_r ? {8'h00, wdata_r[15:8]} : wdata_r;
            if (floatBus_r || !dataPh) begin
                ext_data_bus_oe <= 2'b00; // R11
            end else if (second_r) begin
                ext_data_bus_oe <= {1'b0, wrLo}; // R25
            end else begin
                ext_data_bus_oe <= {wrHi, wrLo}; // R11
            end
        end
    end

    // grant lags the float by a cycle so the requester never sees a fight
    always_ff @(posedge sys_clk or negedge rstN_r) begin
        if (!rstN_r) begin
            dma_grant <= 1'b0;
            processor_clock_output <= 1'b0;
        end else begin
            dma_grant <= grant_r; // R20
            processor_clock_output <= procClkHigh; // R24
        end
    end

    // read return is kept apart from the pin drivers
    always_ff @(posedge sys_clk or negedge rstN_r) begin
        if (!rstN_r) begin
            rdWord <= DATA_RST;
            rdByte <= 8'h00;
        end else begin
            rdWord <= rword_r;
            rdByte <= hiByte_r ? rword_r[15:8] : rword_r[7:0]; // R23
        end
    end
endmodule // emi_ctrl
`default_nettype wire

// *** core/emi_pkg.sv ***
package emi_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    // processor clock half period in sys_clk cycles (one phase)
    localparam int PHASE_CYC = 1;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [15:0] DATA_RST = 16'h0000;
    typedef enum logic [2:0] {
        EMI_IDLE, EMI_ADDR_SETUP, EMI_DATA_SETUP, EMI_WAIT1, EMI_WAIT2,
        EMI_XFER, EMI_HOLD
    } emi_state_t;
endpackage

// *** core/emi_clkgen.sv ***
`timescale 1ns/1ps
`default_nettype none
module emi_clkgen
    import emi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstN,
    output logic phaseTick,
    output logic procClkHigh
);
    logic [7:0] cnt_r;
    logic lastCnt;
    assign lastCnt = (cnt_r == 8'(PHASE_CYC - 1));
    assign phaseTick = lastCnt;
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            cnt_r <= 8'h00;
            procClkHigh <= 1'b1;
        end else begin
            cnt_r <= lastCnt ? 8'h00 : cnt_r + 8'h01;
            if (lastCnt) begin
                procClkHigh <= ~procClkHigh;
            end
        end
    end
endmodule // emi_clkgen
`default_nettype wire

// *** verification/emi_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module emi_ctrl_assertions
    import emi_pkg::*;
#(parameter int AW = ADDR_W, parameter int DW = DATA_W) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [AW-1:0] ext_addr_bus,
    input wire logic ext_addr_bus_oe,
    input wire logic [1:0] ext_data_bus_oe,
    input wire logic ext_chip_select_n,
    input wire logic ext_chip_select_n_oe,
    input wire logic [1:0] byte_write_strobes_n,
    input wire logic byte_write_strobes_n_oe,
    input wire logic dma_grant,
    input wire logic processor_clock_output
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire logic floated;
    wire logic ceLow;
    assign floated = !ext_addr_bus_oe && ext_data_bus_oe == 2'b00
        && !ext_chip_select_n_oe && !byte_write_strobes_n_oe;
    assign ceLow = !ext_chip_select_n && ext_chip_select_n_oe;
    sequence ce_open;
        $fell(ext_chip_select_n) ##0 ext_chip_select_n_oe;
    endsequence
    sequence ce_held;
        !ext_chip_select_n [*2];
    endsequence
    a_grant_floats: assert property (dma_grant |-> floated)
        else $error("bus driven while granted");
    a_float_first: assert property ($rose(dma_grant) |-> $past(floated))
        else $error("grant before float");
    a_clk_toggles: assert property ($past(nrst, 4)
        |-> processor_clock_output != $past(processor_clock_output))
        else $error("processor clock stalled");
    a_ce_low_span: assert property (ce_open |-> ce_held)
        else $error("chip select low too short");
    a_strobe_in_ce: assert property ((byte_write_strobes_n_oe
        && byte_write_strobes_n != 2'b11) |-> ceLow)
        else $error("strobe outside chip select");
    a_strobe_gap: assert property (ce_open
        |-> $past(byte_write_strobes_n) == 2'b11)
        else $error("strobes not high between cycles");
    a_lane_match: assert property (ce_open
        |-> (ext_data_bus_oe & byte_write_strobes_n) == 2'b00)
        else $error("data lane driven without strobe");
    a_addr_held: assert property (ceLow
        |-> ext_addr_bus_oe && $stable(ext_addr_bus))
        else $error("address moved in cycle");
    a_write_hold: assert property (($rose(ext_chip_select_n)
        && ext_chip_select_n_oe && $past(byte_write_strobes_n) != 2'b11)
        |-> ext_data_bus_oe != 2'b00)
        else $error("write data dropped in hold");
endmodule // emi_ctrl_assertions
`default_nettype wire

// *** verification/emi_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module emi_mem_model (
    input wire logic sys_clk,
    input wire logic [15:0] ext_addr_bus,
    input wire logic [15:0] ext_data_bus_out,
    input wire logic [1:0] ext_data_bus_oe,
    input wire logic ext_chip_select_n,
    input wire logic [1:0] byte_write_strobes_n,
    input wire logic byteWide,
    input wire logic [1:0] waitN,
    output logic [15:0] ext_data_bus_in,
    output logic wait_request
);
    logic [7:0] mem [0:65535];
    logic [15:0] lastBus;
    logic [15:0] rdData;
    logic ceWas;
    logic wrCyc;
    int lowCnt;
    wire logic readDrv;
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'hA5;
        lastBus = 16'h0000;
        ceWas = 1'b1;
        wrCyc = 1'b0;
        lowCnt = 0;
    end
    // drive through the hold phase, let go before the next data setup
    assign readDrv = (!ext_chip_select_n && byte_write_strobes_n == 2'b11)
        || (!ceWas && !wrCyc);
    assign rdData = byteWide ? {~lastBus[15:8], mem[ext_addr_bus]}
        : {mem[{ext_addr_bus[15:1], 1'b1}], mem[{ext_addr_bus[15:1], 1'b0}]};
    // released lanes show the inverse so stale data never matches
    assign ext_data_bus_in[7:0] = ext_data_bus_oe[0] ? ext_data_bus_out[7:0]
        : readDrv ? rdData[7:0] : ~lastBus[7:0];
    assign ext_data_bus_in[15:8] = ext_data_bus_oe[1]
        ? ext_data_bus_out[15:8] : readDrv ? rdData[15:8] : ~lastBus[15:8];
    assign wait_request = lowCnt < 2 * int'(waitN);
    always @(posedge sys_clk) begin
        lastBus <= ext_data_bus_in;
        ceWas <= ext_chip_select_n;
        lowCnt <= ext_chip_select_n ? 0 : lowCnt + 1;
        if (!ext_chip_select_n) wrCyc <= byte_write_strobes_n != 2'b11;
        if (!ext_chip_select_n && byteWide && !byte_write_strobes_n[0])
            mem[ext_addr_bus] <= ext_data_bus_in[7:0];
        for (int k = 0; k < 2; k++)
            if (!ext_chip_select_n && !byteWide && !byte_write_strobes_n[k])
                mem[{ext_addr_bus[15:1], k[0]}] <= ext_data_bus_in[8*k +: 8];
    end
endmodule // emi_mem_model
`default_nettype wire

// *** verification/external_static_memory_interface_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module external_static_memory_interface_tb;
    import emi_pkg::*;
    logic sys_clk, nrst, reqValid, reqExt, reqWrite, reqByte, bwSel, dmaReq;
    logic reqReady, rdValid, addrOe, ceN, ceOe, wsOe, grant, pclk, waitReq;
    logic [1:0] waitN, busOe, wsN;
    logic [7:0] rdByte;
    logic [15:0] reqAddr, reqWdata, rdWord, addrBus, busOut, busIn;
    logic [7:0] refMem [0:65535];
    int err_total, comparisons, cycles;
    emi_ctrl uut (.sys_clk(sys_clk), .nrst(nrst), .reqValid(reqValid),
        .reqExt(reqExt), .reqWrite(reqWrite), .reqByte(reqByte),
        .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady),
        .rdByte(rdByte), .rdWord(rdWord), .rdValid(rdValid),
        .ext_addr_bus(addrBus), .ext_addr_bus_oe(addrOe),
        .ext_data_bus_in(busIn), .ext_data_bus_out(busOut),
        .ext_data_bus_oe(busOe), .ext_chip_select_n(ceN),
        .ext_chip_select_n_oe(ceOe), .byte_write_strobes_n(wsN),
        .byte_write_strobes_n_oe(wsOe), .byte_wide_select(bwSel),
        .wait_request(waitReq), .dma_request(dmaReq), .dma_grant(grant),
        .processor_clock_output(pclk));
    // undriven control lines are pulled up
    emi_mem_model u_mem (.sys_clk(sys_clk), .ext_addr_bus(addrBus),
        .ext_data_bus_out(busOut), .ext_data_bus_oe(busOe),
        .ext_chip_select_n(ceOe ? ceN : 1'b1),
        .byte_write_strobes_n(wsOe ? wsN : 2'b11), .byteWide(bwSel),
        .waitN(waitN), .ext_data_bus_in(busIn), .wait_request(waitReq));
    task automatic check(input string what, input logic [15:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic access(input logic ext, w, b, input logic [15:0] a, d);
        int n;
        int pulses;
        logic ceSeen;
        n = 0;
        pulses = 0;
        ceSeen = 1'b0;
        reqValid <= 1'b1;
        reqExt <= ext;
        reqWrite <= w;
        reqByte <= b;
        reqAddr <= a;
        reqWdata <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (reqReady !== 1'b1 && n < 60);
        reqValid <= 1'b0;
        check("taken", 16'h0001, {15'h0000, reqReady});
        // longest case: two byte cycles with three waits each
        repeat (40) begin
            @(posedge sys_clk);
            if (ceN === 1'b0) ceSeen = 1'b1;
            if (rdValid === 1'b1) pulses++;
        end
        check("chip select", {15'h0000, ext}, {15'h0000, ceSeen});
        if (ext && w && b) refMem[a] = a[0] ? d[15:8] : d[7:0];
        else if (ext && w) {refMem[a | 16'h0001], refMem[a]} = d;
        else if (ext) begin
            check("read done", 16'h0001, pulses[15:0]);
            if (b) check("read byte", {8'h00, refMem[a]}, {8'h00, rdByte});
            else check("read word", {refMem[a | 16'h0001], refMem[a]}, rdWord);
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        logic [15:0] a;
        {nrst, reqValid, reqExt, reqWrite, reqByte, bwSel, dmaReq} = 7'h00;
        {reqAddr, reqWdata, waitN} = 34'h0;
        err_total = 0;
        comparisons = 0;
        cycles = 0;
        for (int i = 0; i < 65536; i++) refMem[i] = i[7:0] ^ 8'hA5;
        void'($urandom(32'h4fea1cd2));
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        for (int m = 0; m < 16; m++) begin
            bwSel <= m[0];
            waitN <= 2'(m % 3);
            a = 16'h9020 + 16'(m[3:2]);
            if (!m[1]) a[0] = 1'b0;
            access(1'b1, 1'b1, m[1], a, 16'h5AC3 ^ 16'(m * 16'h1111));
            access(1'b1, 1'b0, m[1], a, 16'h0000);
        end
        $display("test directed done");
        for (int m = 0; m < 24; m++) begin
            bwSel <= 1'($urandom % 2);
            waitN <= 2'($urandom % 3);
            a = 16'h9000 | 16'($urandom % 8);
            if (m % 2 == 0) a[0] = 1'b0;
            access(($urandom % 4) != 0, 1'($urandom % 2), m % 2 == 1, a,
                16'($urandom));
        end
        $display("test random done");
        dmaReq <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check("grant", 16'h0001, {15'h0000, grant});
        check("address float", 16'h0000, {15'h0000, addrOe});
        dmaReq <= 1'b0;
        repeat (10) @(posedge sys_clk);
        check("grant gone", 16'h0000, {15'h0000, grant});
        access(1'b1, 1'b0, 1'b0, 16'h9020, 16'h0000);
        $display("test dma done");
        conclude();
    end
endmodule // external_static_memory_interface_tb
bind emi_ctrl emi_ctrl_assertions #(.AW(AW), .DW(DW)) u_chk (
    .sys_clk(sys_clk), .nrst(nrst), .ext_addr_bus(ext_addr_bus),
    .ext_addr_bus_oe(ext_addr_bus_oe), .ext_data_bus_oe(ext_data_bus_oe),
    .ext_chip_select_n(ext_chip_select_n),
    .ext_chip_select_n_oe(ext_chip_select_n_oe),
    .byte_write_strobes_n(byte_write_strobes_n),
    .byte_write_strobes_n_oe(byte_write_strobes_n_oe),
    .dma_grant(dma_grant), .processor_clock_output(processor_clock_output));
`default_nettype wire
